/* rtc_alarm_watchdog_irq_tb_top.sv */
`timescale 1ns/1ps
module rtc_alarm_watchdog_irq_tb_top;
    // ------------------------------------------------------------
    // stimulus and results
    // ------------------------------------------------------------
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic hund_tick_i = 1'b0, hund_last_i = 1'b0, sec_wrap_i = 1'b0;
    logic [7:0] cur_min_i = 8'h00, cur_hour_i = 8'h00, cur_day_i = 8'h01;
    logic vcc_ok = 1'b1; // supply present pin
    logic ce_n, we_n, oe_n, data_oe, hres_stb, transfer_en, a_oe, b, b_oe, fire;
    logic [3:0] addr;
    logic [2:0] m, x;
    logic [7:0] wdata, rdata, hres, exp_v, amin, ahr, aday;
    logic [7:0] exp_q[$];
    logic [5:0] tcase[7] = '{6'h00, 6'h04, 6'h24, 6'h22, 6'h36, 6'h31, 6'h3F}; // {masks, bad fields}
    logic [3:0] ra[7] = '{4'h3, 4'h5, 4'h7, 4'hC, 4'hD, 4'h0, 4'hE};
    int n_fail = 0, checks_done = 0, cyc = 0, seed = 22223;
    initial forever #25 mclk_i = ~mclk_i;
    rtcaw_top #(.PULSE_CYC(20)) dut (.mclk_i(mclk_i), .rst_i(rst_i), .ce_n_i(ce_n), .we_n_i(we_n),
        .oe_n_i(oe_n), .addr_i(addr), .data_i(wdata), .data_o(rdata), .data_oe_o(data_oe),
        .hund_tick_i(hund_tick_i), .hund_last_i(hund_last_i), .sec_wrap_i(sec_wrap_i),
        .cur_min_i(cur_min_i), .cur_hour_i(cur_hour_i), .cur_day_i(cur_day_i),
        .transfer_en_o(transfer_en), .vcc_ok_i(vcc_ok), .irq_out_a_n_o(), .irq_out_a_n_oe_o(a_oe),
        .irq_out_b_o(b), .irq_out_b_oe_o(b_oe));
    rtcaw_host host (.mclk_i(mclk_i), .ce_n_o(ce_n), .we_n_o(we_n), .oe_n_o(oe_n), .addr_o(addr),
        .wdata_o(wdata), .rdata_i(rdata), .rdata_oe_i(data_oe), .res_stb_o(hres_stb), .res_o(hres));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task chk(input logic [7:0] got, input logic [7:0] exp);
        checks_done++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // pins as {transfer_en, a active, b active, b level}
    task chk_pin(input logic [3:0] e);
        chk({4'h0, transfer_en, a_oe, b_oe, b}, {4'h0, e});
    endtask
    task rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.xfer(1'b0, a, 8'h00);
    endtask
    task wr(input logic [3:0] a, input logic [7:0] d);
        host.xfer(1'b1, a, d);
    endtask
    // one hundredths tick, then 8 quiet clocks
    task tk(input logic l, input logic w);
        @(negedge mclk_i);
        hund_last_i = l;
        sec_wrap_i = w;
        hund_tick_i = 1'b1;
        @(negedge mclk_i);
        hund_tick_i = 1'b0;
        repeat (8) @(negedge mclk_i);
    endtask
    function automatic logic [7:0] rbcd(input int lim);
        int v;
        v = {$random(seed)} % lim;
        return 8'((v / 10) * 16 + v % 10);
    endfunction
    task print_verdict;
        $display("checks_done=%0d n_fail=%0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // read results are compared in arrival order
    always @(posedge hres_stb) begin
        exp_v = exp_q.pop_front();
        chk(hres, exp_v);
    end
    // hang guard
    always @(posedge mclk_i) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            print_verdict;
        end
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(negedge mclk_i);
        rst_i = 1'b0;
        repeat (4) @(negedge mclk_i);
        rd(4'hB, 8'hCC);
        foreach (ra[i]) rd(ra[i], 8'h00);
        wr(4'hB, 8'hFF);
        rd(4'hB, 8'hFC);
        wr(4'hB, 8'hC8);
        foreach (tcase[i]) begin
            m = tcase[i][5:3];
            x = m | tcase[i][2:0];
            fire = (tcase[i][2:0] & ~m) == 3'h0;
            amin = rbcd(60);
            ahr = rbcd(24);
            aday = 8'({$random(seed)} % 7 + 1);
            wr(4'h3, {m[0], amin[6:0]});
            wr(4'h5, {m[1], ahr[6:0]});
            wr(4'h7, {m[2], aday[6:0]});
            cur_min_i = amin ^ {7'h00, x[0]};
            cur_hour_i = ahr ^ {7'h00, x[1]};
            cur_day_i = aday ^ {7'h00, x[2]};
            tk(1'b1, 1'b0);
            tk(1'b0, 1'b1);
            chk_pin(4'h8);
            tk(1'b1, 1'b1);
            // routing bit set: the tod alarm lands on output a
            chk_pin({1'b1, fire, 2'b00});
            rd(4'hB, {7'h64, fire});
            rd(4'h3, {m[0], amin[6:0]});
            chk_pin(4'h8);
        end
        wr(4'hD, 8'h00);
        wr(4'hC, 8'h05);
        wr(4'hB, 8'hC4);
        repeat (4) tk(1'b0, 1'b0);
        chk_pin(4'h8);
        tk(1'b0, 1'b0);
        chk_pin(4'hA);
        rd(4'hB, 8'hC6);
        rd(4'hC, 8'h05);
        chk_pin(4'h8);
        wr(4'hB, 8'hB4);
        wr(4'hC, 8'h03);
        repeat (3) tk(1'b0, 1'b0);
        chk_pin(4'hD);
        repeat (20) @(negedge mclk_i);
        chk_pin(4'h9);
        rd(4'hB, 8'hB4);
        repeat (3) tk(1'b0, 1'b0);
        chk_pin(4'hD);
        wr(4'hC, 8'h00);
        wr(4'hB, 8'hB0);
        wr(4'h7, 8'hFF);
        rd(4'h7, 8'h87);
        wr(4'h5, 8'h80);
        wr(4'h3, 8'h80);
        tk(1'b1, 1'b1);
        chk_pin(4'hB);
        // supply gone while the pulse still runs: b may no longer source
        vcc_ok = 1'b0;
        repeat (6) @(negedge mclk_i);
        chk_pin(4'h9);
        repeat (10) tk(1'b0, 1'b0);
        vcc_ok = 1'b1;
        chk_pin(4'h9);
        wr(4'hB, 8'h3C);
        chk_pin(4'h1);
        rd(4'hB, 8'h3C);
        print_verdict;
    end
endmodule // rtc_alarm_watchdog_irq_tb_top
bind rtcaw_top rtcaw_props #(.PULSE_CYC(PULSE_CYC)) u_props (.mclk_i(mclk_i), .rst_i(rst_i),
    .addr_i(addr_i), .data_o(data_o), .data_oe_o(data_oe_o), .hund_tick_i(hund_tick_i),
    .transfer_en_o(transfer_en_o), .vcc_ok_i(vcc_ok_i), .irq_out_a_n_o(irq_out_a_n_o),
    .irq_out_a_n_oe_o(irq_out_a_n_oe_o), .irq_out_b_o(irq_out_b_o), .irq_out_b_oe_o(irq_out_b_oe_o));

/* rtcaw_consts.vh */
`ifndef RTCAW_CONSTS_VH
`define RTCAW_CONSTS_VH
// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define RTCAW_OFS_MIN_ALM 4'h3
`define RTCAW_OFS_HOUR_ALM 4'h5
`define RTCAW_OFS_DAY_ALM 4'h7
`define RTCAW_OFS_CMD 4'hB
`define RTCAW_OFS_WD_FRAC 4'hC
`define RTCAW_OFS_WD_SEC 4'hD
// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define RTCAW_ALM_MASK_BIT 7
`define RTCAW_DAY_RD_MASK 8'h87
`define RTCAW_CMD_XFER 7
`define RTCAW_CMD_ROUTE 6
`define RTCAW_CMD_BPOL 5
`define RTCAW_CMD_PULSE 4
`define RTCAW_CMD_WDMASK 3
`define RTCAW_CMD_TODMASK 2
`define RTCAW_CMD_WDFLAG 1
`define RTCAW_CMD_TODFLAG 0
`define RTCAW_CMD_WR_MASK 8'hFC
// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define RTCAW_CMD_RST 8'hCC
`define RTCAW_ALM_RST 8'h00
// ------------------------------------------------------------
// timing
// ------------------------------------------------------------
`define RTCAW_CLK_HZ 20000000
`define RTCAW_PULSE_US 3000
`define RTCAW_PULSE_CYC ((`RTCAW_CLK_HZ / 1000000) * `RTCAW_PULSE_US)
`endif

/* rtcaw_host.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// host cpu model, slow sram-style master
// ------------------------------------------------------------
module rtcaw_host (
    // clock
    input wire mclk_i,
    // bus towards the block
    output logic ce_n_o = 1'b1,
    output logic we_n_o = 1'b1,
    output logic oe_n_o = 1'b1,
    output logic [3:0] addr_o = 4'h0,
    output logic [7:0] wdata_o = 8'h00,
    input wire [7:0] rdata_i,
    input wire rdata_oe_i,
    // read result
    output logic res_stb_o = 1'b0,
    output logic [7:0] res_o = 8'h00
);
    // strobes held 10 clocks and idle 6, well past the 3-flop sync
    task automatic xfer(input logic wr, input logic [3:0] a, input logic [7:0] d);
        @(negedge mclk_i);
        addr_o = a;
        wdata_o = d;
        ce_n_o = 1'b0;
        we_n_o = !wr;
        oe_n_o = wr; // oe stays high in writes, no contention
        repeat (10) @(posedge mclk_i);
        res_o = rdata_oe_i ? rdata_i : 8'hXX;
        res_stb_o = !wr;
        @(negedge mclk_i);
        ce_n_o = 1'b1;
        we_n_o = 1'b1;
        oe_n_o = 1'b1;
        wdata_o = ~d; // released data must not keep its value
        res_stb_o = 1'b0;
        repeat (6) @(negedge mclk_i);
    endtask
endmodule // rtcaw_host

/* rtcaw_props.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// port checks for alarm, watchdog and interrupt pins
// ------------------------------------------------------------
module rtcaw_props #(
    parameter PULSE_CYC = 20 // kept for the bind; repetitions below stay short of it
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // host bus
    input wire [3:0] addr_i,
    input wire [7:0] data_o,
    input wire data_oe_o,
    // time link and supply
    input wire hund_tick_i,
    input wire transfer_en_o,
    input wire vcc_ok_i,
    // interrupt pins
    input wire irq_out_a_n_o,
    input wire irq_out_a_n_oe_o,
    input wire irq_out_b_o,
    input wire irq_out_b_oe_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);
    // an irq edge needs a tick; a cmd write may re-route a pending flag
    property p_a_rise;
        $rose(irq_out_a_n_oe_o) |-> $past(hund_tick_i) || $past(hund_tick_i, 2) || $past(hund_tick_i, 3) || addr_i == 4'hB;
    endproperty
    a_a_rise: assert property (p_a_rise) else $error("irq a rose without tick");
    property p_b_rise;
        $rose(irq_out_b_oe_o) |-> $past(hund_tick_i) || $past(hund_tick_i, 2) || $past(hund_tick_i, 3) || addr_i == 4'hB;
    endproperty
    a_b_rise: assert property (p_b_rise) else $error("irq b rose without tick");
    property p_a_sink;
        irq_out_a_n_oe_o |-> !irq_out_a_n_o;
    endproperty
    a_a_sink: assert property (p_a_sink) else $error("irq a not sinking");
    // supply pin runs through the 3-flop sync, so b lets go four edges late
    property p_b_src;
        irq_out_b_oe_o && irq_out_b_o |-> $past(vcc_ok_i, 4);
    endproperty
    a_b_src: assert property (p_b_src) else $error("irq b sources without supply");
    property p_xfer;
        $changed(transfer_en_o) |-> addr_i == 4'hB;
    endproperty
    a_xfer: assert property (p_xfer) else $error("transfer enable moved without cmd write");
    property p_day_rd;
        (data_oe_o && addr_i == 4'h7) [*6] |-> data_o[6:3] == 4'h0;
    endproperty
    a_day_rd: assert property (p_day_rd) else $error("day alarm unused bits read nonzero");
    property p_a_min;
        $rose(irq_out_a_n_oe_o) && addr_i != 4'hB |-> irq_out_a_n_oe_o [*8];
    endproperty
    a_a_min: assert property (p_a_min) else $error("irq a too short");
    property p_b_min;
        $rose(irq_out_b_oe_o) && addr_i != 4'hB |-> irq_out_b_oe_o [*8];
    endproperty
    a_b_min: assert property (p_b_min) else $error("irq b too short");
    c_a: cover property ($rose(irq_out_a_n_oe_o));
    c_b: cover property ($rose(irq_out_b_oe_o));
    c_rd: cover property (data_oe_o [*6]);
endmodule // rtcaw_props

/* rtcaw_sync.v */
`timescale 1ns/1ps
// three-stage synchroniser, change accepted when stages 2 and 3 agree
module rtcaw_sync #(
    parameter W = 1,
    parameter [W-1:0] RST_VAL = {W{1'b1}}
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // data
    input wire [W-1:0] d_i,
    output reg [W-1:0] q_o
);
    reg [W-1:0] s1_q; // metastable stage, read only by s2
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer i;

    // shift chain and agreement filter
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            s1_q <= RST_VAL;
            s2_q <= RST_VAL;
            s3_q <= RST_VAL;
            q_o <= RST_VAL;
        end else begin
            s1_q <= d_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    q_o[i] <= s2_q[i];
                end
            end
        end
    end
endmodule // rtcaw_sync

/* rtcaw_top.v */
// Overview of operation
// [RULE1] day alarm bits 3..6 read zero
// [RULE2] bit 7 of alarm registers masks compare
// [RULE3] no masks: day, hour, minute must match
// [RULE4] day masked: daily on hour and minute
// [RULE5] day, hour masked: hourly on minute
// [RULE6] all masked: each seconds wrap to zero
// [RULE7] host uses only four mask combinations
// [RULE8] alarm registers use time register bcd format
// [RULE9] alarm register access clears tod flag
// [RULE10] watchdog holds four bcd digit reload
// [RULE11] watchdog access reloads, clears flag
// [RULE12] zero reached raises irq, then repeats
// [RULE13] watchdog reads return reload value
// [RULE14] both watchdog bytes zero disables watchdog
// [RULE15] transfer bit zero freezes time registers
// [RULE16] routing bit selects which output carries which
// [RULE17] out b polarity: source or sink
// [RULE18] level mode holds; pulse mode 3 ms
// [RULE19] watchdog mask blocks watchdog output
// [RULE20] tod mask blocks tod output
// [RULE21] watchdog flag read only, pulse-limited
// [RULE22] tod flag read only, pulse-limited
// [RULE23] tod compare during hundredths value 99
`timescale 1ns/1ps
`include "rtcaw_consts.vh"
module rtcaw_top #(
    parameter PULSE_CYC = `RTCAW_PULSE_CYC // 3 ms minimum pulse
) (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // asynchronous host bus
    input wire ce_n_i,
    input wire we_n_i,
    input wire oe_n_i,
    input wire [3:0] addr_i,
    input wire [7:0] data_i,
    output reg [7:0] data_o,
    output wire data_oe_o,
    // time counter link (same clock)
    input wire hund_tick_i,
    input wire hund_last_i,
    input wire sec_wrap_i,
    input wire [7:0] cur_min_i,
    input wire [7:0] cur_hour_i,
    input wire [7:0] cur_day_i,
    output wire transfer_en_o,
    // supply presence (pin)
    input wire vcc_ok_i,
    // interrupt pins, a open drain, b source or sink
    output wire irq_out_a_n_o,
    output wire irq_out_a_n_oe_o,
    output wire irq_out_b_o,
    output wire irq_out_b_oe_o
);
    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    wire ce_n_s, we_n_s, oe_n_s, vcc_ok_s;
    wire [3:0] addr_s;
    wire [7:0] wdat_s;
    rtcaw_sync #(.W(16), .RST_VAL(16'hFF8E)) u_sync (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .d_i({ce_n_i, we_n_i, oe_n_i, vcc_ok_i, addr_i, data_i}),
        .q_o({ce_n_s, we_n_s, oe_n_s, vcc_ok_s, addr_s, wdat_s})
    );

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    reg [7:0] min_alm_q, hour_alm_q, day_alm_q; // [RULE8] stored bcd as written, day alarm keeps only bits 7 and 2..0
    reg [7:0] wd_frac_q, wd_sec_q; // reload value
    reg [7:0] cmd_q; // control bits 7..2
    reg tod_flag_q, wd_flag_q; // sticky/pulse flags
    reg [31:0] tod_pcnt_q, wd_pcnt_q; // pulse timers
    reg acc_q; // access in progress
    reg wr_q; // write in progress
    reg [3:0] acc_addr_q; // address of current write
    reg [7:0] wdat_q; // write data held while the strobe is low
    reg wr_end_q; // write end, one cycle late

    // access phases: start edge of ce, end edge of ce or we
    wire acc_now = !ce_n_s;
    wire acc_start = acc_now && !acc_q;
    wire wr_now = !ce_n_s && !we_n_s;
    wire wr_end = wr_q && !wr_now; // latch data on trailing edge

    function is_alm;
        input [3:0] a;
        begin
            is_alm = (a == `RTCAW_OFS_MIN_ALM) || (a == `RTCAW_OFS_HOUR_ALM) || (a == `RTCAW_OFS_DAY_ALM);
        end
    endfunction

    function is_wd;
        input [3:0] a;
        begin
            is_wd = (a == `RTCAW_OFS_WD_FRAC) || (a == `RTCAW_OFS_WD_SEC);
        end
    endfunction

    // any read or write start counts as an access
    wire alm_access = acc_start && is_alm(addr_s); // [RULE9]
    // restart a cycle after the write end, once the reload byte has landed
    wire wd_access = (acc_start && is_wd(addr_s)) || (wr_end_q && is_wd(acc_addr_q)); // [RULE11]

    // ------------------------------------------------------------
    // watchdog
    // ------------------------------------------------------------
    wire wd_expire;
    rtcaw_wdog u_wdog (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .reload_i({wd_sec_q, wd_frac_q}), // [RULE10]
        .restart_i(wd_access),
        .tick_i(hund_tick_i),
        .expire_o(wd_expire)
    );

    // ------------------------------------------------------------
    // time-of-day match
    // ------------------------------------------------------------
    wire min_m = min_alm_q[`RTCAW_ALM_MASK_BIT] || (min_alm_q[6:0] == cur_min_i[6:0]); // [RULE2]
    wire hour_m = hour_alm_q[`RTCAW_ALM_MASK_BIT] || (hour_alm_q[6:0] == cur_hour_i[6:0]);
    wire day_m = day_alm_q[`RTCAW_ALM_MASK_BIT] || (day_alm_q[2:0] == cur_day_i[2:0]);
    wire all_mask = min_alm_q[7] && hour_alm_q[7] && day_alm_q[7];
    // one evaluation per minute, in the final hundredth before rollover
    wire tod_hit = hund_tick_i && hund_last_i && sec_wrap_i && // [RULE23]
        (all_mask || (min_m && hour_m && day_m)); // [RULE3] [RULE4] [RULE5] [RULE6]

    // ------------------------------------------------------------
    // bus access tracking and register writes
    // ------------------------------------------------------------
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            acc_q <= 1'b0;
            wr_q <= 1'b0;
            acc_addr_q <= 4'h0;
            wdat_q <= 8'h00;
            wr_end_q <= 1'b0;
            min_alm_q <= `RTCAW_ALM_RST;
            hour_alm_q <= `RTCAW_ALM_RST;
            day_alm_q <= `RTCAW_ALM_RST;
            wd_frac_q <= 8'h00;
            wd_sec_q <= 8'h00;
            cmd_q <= `RTCAW_CMD_RST;
        end else begin
            acc_q <= acc_now;
            wr_q <= wr_now;
            wr_end_q <= wr_end;
            // address and data taken while the strobe is low; the host may
            // move them in the same cycle as it lets the strobe go
            if (wr_now) begin
                acc_addr_q <= addr_s;
                wdat_q <= wdat_s;
            end
            // write lands on the trailing edge of the write strobe
            if (wr_end) begin
                case (acc_addr_q)
                    `RTCAW_OFS_MIN_ALM: begin
                        min_alm_q <= wdat_q;
                    end
                    `RTCAW_OFS_HOUR_ALM: begin
                        hour_alm_q <= wdat_q;
                    end
                    `RTCAW_OFS_DAY_ALM: begin
                        day_alm_q <= wdat_q & `RTCAW_DAY_RD_MASK; // [RULE1]
                    end
                    `RTCAW_OFS_CMD: begin
                        cmd_q <= wdat_q & `RTCAW_CMD_WR_MASK; // flags not writable
                    end
                    `RTCAW_OFS_WD_FRAC: begin
                        wd_frac_q <= wdat_q;
                    end
                    `RTCAW_OFS_WD_SEC: begin
                        wd_sec_q <= wdat_q;
                    end
                    default: begin
                        // other offsets belong to other blocks
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------
    // flags and pulse timers; a new event beats the clear
    // ------------------------------------------------------------
    wire pulse_mode = cmd_q[`RTCAW_CMD_PULSE];
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            tod_flag_q <= 1'b0;
            wd_flag_q <= 1'b0;
            tod_pcnt_q <= 32'h0;
            wd_pcnt_q <= 32'h0;
        end else begin
            // tod flag [RULE22]
            if (tod_hit) begin
                tod_flag_q <= 1'b1;
                tod_pcnt_q <= PULSE_CYC;
            end else if (alm_access) begin
                tod_flag_q <= 1'b0; // [RULE9]
                tod_pcnt_q <= 32'h0;
            end else if (tod_pcnt_q != 32'h0) begin
                tod_pcnt_q <= tod_pcnt_q - 32'h1;
                if (pulse_mode && tod_pcnt_q == 32'h1) begin
                    tod_flag_q <= 1'b0; // [RULE18]
                end
            end else if (pulse_mode) begin
                tod_flag_q <= 1'b0;
            end
            // watchdog flag [RULE21]
            if (wd_expire) begin
                wd_flag_q <= 1'b1; // [RULE12]
                wd_pcnt_q <= PULSE_CYC;
            end else if (wd_access) begin
                wd_flag_q <= 1'b0; // [RULE11]
                wd_pcnt_q <= 32'h0;
            end else if (wd_pcnt_q != 32'h0) begin
                wd_pcnt_q <= wd_pcnt_q - 32'h1;
                if (pulse_mode && wd_pcnt_q == 32'h1) begin
                    wd_flag_q <= 1'b0;
                end
            end else if (pulse_mode) begin
                wd_flag_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupt routing and drive
    // ------------------------------------------------------------
    wire tod_act = tod_flag_q && !cmd_q[`RTCAW_CMD_TODMASK]; // [RULE20]
    wire wd_act = wd_flag_q && !cmd_q[`RTCAW_CMD_WDMASK]; // [RULE19]
    wire route = cmd_q[`RTCAW_CMD_ROUTE];
    wire a_act = route ? tod_act : wd_act; // [RULE16]
    wire b_act = route ? wd_act : tod_act;
    wire b_src = cmd_q[`RTCAW_CMD_BPOL];
    // output a is open drain, only ever pulls low
    assign irq_out_a_n_o = 1'b0;
    assign irq_out_a_n_oe_o = a_act;
    // output b sources only with supply present, otherwise released; sinks when the polarity bit is clear
    assign irq_out_b_o = b_src; // [RULE17]
    assign irq_out_b_oe_o = b_act && (!b_src || vcc_ok_s);

    // ------------------------------------------------------------
    // transfer freeze and read path
    // ------------------------------------------------------------
    assign transfer_en_o = cmd_q[`RTCAW_CMD_XFER]; // [RULE15]
    assign data_oe_o = !ce_n_s && !oe_n_s && we_n_s;

    // read data from flops; watchdog returns stored reload only
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            data_o <= 8'h00;
        end else begin
            case (addr_s)
                `RTCAW_OFS_MIN_ALM: data_o <= min_alm_q;
                `RTCAW_OFS_HOUR_ALM: data_o <= hour_alm_q;
                `RTCAW_OFS_DAY_ALM: data_o <= day_alm_q & `RTCAW_DAY_RD_MASK; // [RULE1]
                `RTCAW_OFS_CMD: data_o <= {cmd_q[7:2], wd_flag_q, tod_flag_q};
                `RTCAW_OFS_WD_FRAC: data_o <= wd_frac_q; // [RULE13]
                `RTCAW_OFS_WD_SEC: data_o <= wd_sec_q; // [RULE13]
                default: data_o <= 8'h00;
            endcase
        end
    end
    // [RULE14] zero reload holds the counter idle in the watchdog
endmodule // rtcaw_top

/* rtcaw_wdog.v */
`timescale 1ns/1ps
// bcd countdown in hundredths; reload on access or at zero
module rtcaw_wdog (
    // clock and reset
    input wire mclk_i,
    input wire rst_i,
    // control
    input wire [15:0] reload_i,
    input wire restart_i,
    input wire tick_i,
    // event
    output reg expire_o
);
    reg [15:0] cnt_q; // live count, never visible to the host

    // one bcd digit decrement with borrow
    function [4:0] rtcaw_dec;
        input [3:0] d;
        input b;
        begin
            if (!b) rtcaw_dec = {1'b0, d};
            else if (d == 4'h0) rtcaw_dec = {1'b1, 4'h9};
            else rtcaw_dec = {1'b0, d - 4'h1};
        end
    endfunction

    reg [4:0] d0, d1, d2, d3;
    always @* begin
        d0 = rtcaw_dec(cnt_q[3:0], 1'b1);
        d1 = rtcaw_dec(cnt_q[7:4], d0[4]);
        d2 = rtcaw_dec(cnt_q[11:8], d1[4]);
        d3 = rtcaw_dec(cnt_q[15:12], d2[4]);
    end

    // countdown; a zero reload disables everything
    always @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_q <= 16'h0000;
            expire_o <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (restart_i || reload_i == 16'h0000) begin // [RULE14]
                cnt_q <= reload_i; // [RULE11]
            end else if (tick_i) begin
                if (cnt_q == 16'h0001 || cnt_q == 16'h0000) begin
                    expire_o <= 1'b1; // [RULE12]
                    cnt_q <= reload_i; // repeats without access
                end else begin
                    cnt_q <= {d3[3:0], d2[3:0], d1[3:0], d0[3:0]};
                end
            end
        end
    end
endmodule // rtcaw_wdog
